// *** pam_pkg.sv ***
`default_nettype none
package pam_pkg;
  // Clock rate and the seconds timebase derived from it.
  localparam int CLK_MHZ  = 200;
  localparam int SEC_CYC  = CLK_MHZ * 1000000;
  // Alarm durations in their own unit, then in seconds.
  localparam int ALARM_MIN = 2;
  localparam int ALARM_S   = ALARM_MIN * 60;
  localparam int HOLD_MIN  = 2;
  localparam int HOLD_S    = HOLD_MIN * 60;
  // Remaining battery time, in minutes, that raises the power loss alarm.
  localparam logic [7:0] TPL_LEFT_MIN = 8'h05;
  // Oxygen setting that means room air, 21 percent.
  localparam logic [6:0] O2_AIR_PCT = 7'h15;
  // Register byte offsets on the bus.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_MODE = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  // Field positions and reset values.
  localparam int CTRL_PCT_LSB  = 0;
  localparam int CTRL_DIS_BIT  = 8;
  localparam int STAT_ST_LSB   = 8;
  localparam logic [6:0] PCT_RST  = 7'h15;
  localparam logic [3:0] MODE_RST = 4'h0;
  // Timer slots, one for each timed alarm.
  localparam int NT      = 5;
  localparam int TM_ML   = 0;
  localparam int TM_EXT  = 1;
  localparam int TM_INT  = 2;
  localparam int TM_SWI  = 3;
  localparam int TM_HOLD = 4;

  // Sequencer states, Gray coded along boot, run, warn, shut, safe.
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_RUN  = 3'b001,
    ST_WARN = 3'b011,
    ST_SHUT = 3'b010,
    ST_SAFE = 3'b110
  } pam_state_t;

  // Condition detectors and sensors.
  typedef struct packed {
    logic       mains_ok;
    logic       int_supplying;
    logic       ext_supplying;
    logic       int_low;
    logic       int_absent;
    logic       ext_low;
    logic       ext_replaced;
    logic       batt_depleted;
    logic [7:0] batt_left_min;
    logic       o2_pressure_ok;
    logic       o2_sensor_bad;
    logic       speaker_fail;
  } pam_sense_t;

  // Annunciators, lamps and actuators.
  typedef struct packed {
    logic tone_medium;
    logic tone_high;
    logic backup_speaker;
    logic mains_loss_msg;
    logic caution_bar;
    logic int_batt_ind;
    logic ext_batt_ind;
    logic int_level_on;
    logic alarm_status;
    logic power_loss_msg;
    logic low_int_msg;
    logic mains_connect_prompt;
    logic safety_valve_open;
  } pam_ind_t;
endpackage : pam_pkg
`default_nettype wire

// *** pam_timer.sv ***
`default_nettype none
module pam_timer
  import pam_pkg::*;
#(
  parameter int LIMIT = ALARM_S
) (
  // Clock and reset.
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  // Control.
  input  wire logic tick_in,
  input  wire logic start_in,
  input  wire logic stop_in,
  // Status.
  output var  logic busy_out,
  output var  logic done_out
);
  localparam logic [15:0] LIM = 16'(LIMIT);
  logic [15:0] count;

  // Start restarts from zero even when already running.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count    <= 16'h0000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count    <= 16'h0000;
        busy_out <= 1'b1;
      end else if (stop_in) begin
        busy_out <= 1'b0;
      end else if (busy_out && tick_in) begin
        if (count == LIM - 16'h0001) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end
endmodule : pam_timer
`default_nettype wire

// *** pam_top.sv ***
// Implementation choices: the register offsets and the APB register port.
`default_nettype none
module pam_top
  import pam_pkg::*;
#(
  parameter int CYC_PER_SEC = SEC_CYC,
  parameter int ALARM_SEC   = ALARM_S,
  parameter int HOLD_SEC    = HOLD_S
) (
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // APB slave.
  input  wire logic [11:0] paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output var  logic [31:0] prdata_out,
  output var  logic        pready_out,
  output var  logic        pslverr_out,
  // Sensors, keys and self test.
  input  wire pam_sense_t  sense_in,
  input  wire logic        reset_key_in,
  input  wire logic        power_on_self_test_done_in,
  // Annunciation and sequencing.
  output var  pam_ind_t    ind_out,
  output var  logic        power_on_self_test_run_out,
  output var  logic [3:0]  mode_out,
  output var  logic        resume_out,
  output var  logic [7:0]  alarms_out
);
  pam_sense_t  s;
  pam_ind_t    next_ind;
  pam_state_t  state;
  logic [31:0] sec_cnt;
  logic        tick;
  logic        blink;
  logic [6:0]  o2_pct;
  logic        o2_dis;
  logic [3:0]  mode;
  logic        mains_q;
  logic        ext_sup_q;
  logic        dep_q;
  logic        from_shut;
  logic        ml_act;
  logic        ml_steady;
  logic        tpl;
  logic        ext_low;
  logic        ext_done;
  logic        int_low;
  logic        int_done;
  logic        o2_sup;
  logic        o2_sen;
  logic        spk;
  logic        swi;
  logic        on_batt;
  logic        mains_fall;
  logic        mains_rise;
  logic        in_power_on_self_test;
  logic        tpl_cond;
  logic [NT-1:0] tm_start;
  logic [NT-1:0] tm_stop;
  logic [NT-1:0] tm_busy;
  logic [NT-1:0] tm_done;
  logic        wr_acc;
  logic        hit;

  assign s = sense_in;

  // Seconds timebase; the blink phase toggles once a second.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sec_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
      blink   <= 1'b0;
    end else begin
      tick <= (sec_cnt == 32'(CYC_PER_SEC - 1));
      if (sec_cnt == 32'(CYC_PER_SEC - 1)) begin
        sec_cnt <= 32'h0000_0000;
        blink   <= ~blink;
      end else begin
        sec_cnt <= sec_cnt + 32'h0000_0001;
      end
    end
  end

  // Edge detection on supply conditions.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mains_q   <= 1'b1;
      ext_sup_q <= 1'b0;
      dep_q     <= 1'b0;
    end else begin
      mains_q   <= s.mains_ok;
      ext_sup_q <= s.ext_supplying;
      dep_q     <= s.batt_depleted;
    end
  end

  assign on_batt    = s.int_supplying | s.ext_supplying;
  assign mains_fall = mains_q & ~s.mains_ok;
  assign mains_rise = ~mains_q & s.mains_ok;
  assign in_power_on_self_test    = (state == ST_BOOT) || (state == ST_SHUT);
  assign tpl_cond   = ~s.mains_ok & on_batt &
                      (s.batt_left_min <= TPL_LEFT_MIN);

  // Timer controls, one slot per timed alarm.
  always_comb begin
    tm_start          = '0;
    tm_stop           = '0;
    tm_start[TM_ML]   = mains_fall & on_batt;
    tm_stop[TM_ML]    = mains_rise | reset_key_in;
    tm_start[TM_EXT]  = in_power_on_self_test & s.mains_ok & s.ext_low & ~ext_done &
                        ~ext_low & (s.int_low | s.int_absent);
    tm_stop[TM_EXT]   = s.ext_replaced;
    tm_start[TM_INT]  = in_power_on_self_test & s.mains_ok & s.int_low & ~int_done &
                        ~int_low;
    tm_start[TM_SWI]  = ext_sup_q & ~s.ext_supplying & s.int_supplying;
    tm_stop[TM_SWI]   = mains_rise | s.ext_replaced;
    tm_start[TM_HOLD] = s.batt_depleted & ~dep_q;
  end

  // Independent restartable timers on the shared timebase.
  for (genvar i = 0; i < NT; i++) begin : g_tm
    pam_timer #(
      .LIMIT ((i == TM_HOLD) ? HOLD_SEC : ALARM_SEC)
    ) u_tm (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .tick_in    (tick),
      .start_in   (tm_start[i]),
      .stop_in    (tm_stop[i]),
      .busy_out   (tm_busy[i]),
      .done_out   (tm_done[i])
    );
  end

  // Mains loss: flashing phase, then steady until mains or the reset key.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ml_act    <= 1'b0;
      ml_steady <= 1'b0;
    end else begin
      if (tm_start[TM_ML]) ml_act <= 1'b1;
      else if (mains_rise || tm_done[TM_ML] || reset_key_in) ml_act <= 1'b0;
      // Mains return beats the timeout so a steady lamp never outlives it.
      if (mains_rise || reset_key_in) ml_steady <= 1'b0;
      else if (tm_done[TM_ML]) ml_steady <= 1'b1;
    end
  end

  // Power loss: sounds until power returns; the hold timer extends it.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tpl <= 1'b0;
    end else if (tpl_cond) begin
      tpl <= 1'b1;
    end else if (s.mains_ok || (on_batt && !s.batt_depleted)) begin
      tpl <= 1'b0;
    end
  end

  // Self test battery alarms; each is annunciated once per test at most.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_low  <= 1'b0;
      ext_done <= 1'b0;
      int_low  <= 1'b0;
      int_done <= 1'b0;
    end else begin
      if (tm_start[TM_EXT]) ext_low <= 1'b1;
      else if (tm_done[TM_EXT] || s.ext_replaced) ext_low <= 1'b0;
      if (ext_low && (tm_done[TM_EXT] || s.ext_replaced)) ext_done <= 1'b1;
      else if (state == ST_SAFE) ext_done <= 1'b0;
      if (tm_start[TM_INT]) int_low <= 1'b1;
      else if (tm_done[TM_INT]) int_low <= 1'b0;
      if (tm_done[TM_INT]) int_done <= 1'b1;
    end
  end

  // Oxygen, speaker and battery switch alarms.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      o2_sup <= 1'b0;
      o2_sen <= 1'b0;
      spk    <= 1'b0;
      swi    <= 1'b0;
    end else begin
      o2_sup <= ~s.o2_pressure_ok & (o2_pct != O2_AIR_PCT);
      if (s.o2_sensor_bad) o2_sen <= 1'b1;
      else if (reset_key_in) o2_sen <= 1'b0;
      if (s.speaker_fail) spk <= 1'b1;
      else if (reset_key_in) spk <= 1'b0;
      if (tm_start[TM_SWI]) swi <= 1'b1;
      else if (tm_done[TM_SWI] || tm_stop[TM_SWI]) swi <= 1'b0;
    end
  end

  // Shutdown and self test sequencer.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state      <= ST_BOOT;
      from_shut  <= 1'b0;
      resume_out <= 1'b0;
    end else begin
      resume_out <= 1'b0;
      case (state)
        ST_BOOT: begin
          if (power_on_self_test_done_in) begin
            state      <= ST_RUN;
            resume_out <= from_shut;
            from_shut  <= 1'b0;
          end
        end
        ST_RUN: begin
          if (tpl) state <= ST_WARN;
        end
        ST_WARN: begin
          if (s.mains_ok) state <= ST_RUN;
          else if (s.batt_depleted) state <= ST_SHUT;
        end
        ST_SHUT: begin
          from_shut <= 1'b1;
          if (power_on_self_test_done_in) state <= ST_SAFE;
        end
        ST_SAFE: begin
          if (s.mains_ok) state <= ST_BOOT;
        end
        default: state <= ST_BOOT;
      endcase
    end
  end

  // Indicator mapping; flashing follows the one second blink phase.
  always_comb begin
    next_ind                = '0;
    next_ind.tone_medium    = ml_act | swi;
    next_ind.tone_high      = tpl | tm_busy[TM_HOLD] | ext_low | int_low |
                              o2_sup | (o2_sen & ~o2_dis) | spk;
    next_ind.backup_speaker = spk | tm_busy[TM_HOLD] |
                              (state == ST_SAFE);
    next_ind.mains_loss_msg = ml_act ? blink : ml_steady;
    next_ind.caution_bar    = (ml_act | swi) ? blink : ml_steady;
    next_ind.int_batt_ind   = ~s.mains_ok & s.int_supplying & blink;
    next_ind.ext_batt_ind   = ~s.mains_ok & s.ext_supplying & blink;
    next_ind.int_level_on   = ~tpl & (state != ST_SHUT) &
                              (state != ST_SAFE);
    next_ind.alarm_status   = tpl ? blink : next_ind.tone_high;
    next_ind.power_loss_msg = tpl & blink;
    next_ind.low_int_msg    = int_low | (state == ST_SAFE);
    next_ind.mains_connect_prompt = (state == ST_SAFE);
    next_ind.safety_valve_open    = (state == ST_SAFE) ||
                                    (state == ST_SHUT);
  end

  // Outputs come from flops so the lamps never glitch.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ind_out    <= '0;
      alarms_out <= 8'h00;
    end else begin
      ind_out    <= next_ind;
      alarms_out <= {swi, spk, o2_sen & ~o2_dis, o2_sup,
                     int_low, ext_low, tpl, ml_act | ml_steady};
    end
  end

  assign power_on_self_test_run_out = in_power_on_self_test;
  assign mode_out     = mode;

  // APB: zero wait states; unmapped addresses answer with an error.
  assign hit         = (paddr_in == OFS_CTRL) || (paddr_in == OFS_MODE) ||
                       (paddr_in == OFS_STAT);
  assign wr_acc      = psel_in & penable_in & pwrite_in & hit;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit;

  // Writable settings; the mode survives shutdown for the resume.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      o2_pct <= PCT_RST;
      o2_dis <= 1'b0;
      mode   <= MODE_RST;
    end else if (wr_acc) begin
      if (paddr_in == OFS_CTRL && pstrb_in[0])
        o2_pct <= pwdata_in[CTRL_PCT_LSB +: 7];
      if (paddr_in == OFS_CTRL && pstrb_in[1])
        o2_dis <= pwdata_in[CTRL_DIS_BIT];
      if (paddr_in == OFS_MODE && pstrb_in[0])
        mode <= pwdata_in[3:0];
    end
  end

  // Read data is captured in the setup phase and held for the access.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      prdata_out <= 32'h0000_0000;
      if (paddr_in == OFS_CTRL)
        prdata_out <= {23'h0, o2_dis, 1'b0, o2_pct};
      else if (paddr_in == OFS_MODE)
        prdata_out <= {28'h0, mode};
      else if (paddr_in == OFS_STAT)
        prdata_out <= {21'h0, state, alarms_out};
    end
  end

  // Checks on the alarm behaviour.
  property p_ml_return;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      mains_rise |=> !ml_act && !ml_steady;
  endproperty
  a_ml_return: assert property (p_ml_return)
    else $error("mains loss alarm kept after mains return");

  property p_ml_tone;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      ml_act |=> ind_out.tone_medium;
  endproperty
  a_ml_tone: assert property (p_ml_tone)
    else $error("medium tone missing during mains loss");

  property p_ml_steady;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      tm_done[TM_ML] && !mains_rise && !reset_key_in
        |=> ml_steady && !ml_act ##1 ind_out.mains_loss_msg;
  endproperty
  a_ml_steady: assert property (p_ml_steady)
    else $error("mains loss message not steady after timeout");

  property p_tpl_set;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      tpl_cond |=> tpl ##1 !ind_out.int_level_on;
  endproperty
  a_tpl_set: assert property (p_tpl_set)
    else $error("power loss alarm or lamp off missing");

  property p_hold;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      tm_start[TM_HOLD] |=> ##1 (ind_out.backup_speaker [*8]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("backup alarm stopped early after depletion");

  property p_valve;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      state == ST_SAFE |=> ind_out.safety_valve_open;
  endproperty
  a_valve: assert property (p_valve)
    else $error("safety valve not open in safe state");

  property p_ext_gate;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      $rose(ext_low) |-> $past(in_power_on_self_test) && $past(s.mains_ok);
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("low external battery raised outside self test");

  property p_int_once;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      int_done |=> !$rose(int_low);
  endproperty
  a_int_once: assert property (p_int_once)
    else $error("low internal battery annunciated twice");

  property p_o2_air;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      o2_pct == O2_AIR_PCT && $stable(o2_pct) |=> !o2_sup;
  endproperty
  a_o2_air: assert property (p_o2_air)
    else $error("oxygen supply alarm at room air setting");

  property p_spk;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      s.speaker_fail |=> spk ##1 ind_out.backup_speaker;
  endproperty
  a_spk: assert property (p_spk)
    else $error("backup speaker silent on speaker failure");

  property p_sen_latch;
    @(posedge sys_clk_in) disable iff (!rst_b_in)
      o2_sen && !reset_key_in |=> o2_sen;
  endproperty
  a_sen_latch: assert property (p_sen_latch)
    else $error("oxygen sensor alarm cleared without reset key");
endmodule : pam_top
`default_nettype wire

// *** pam_sense_model.sv ***
`default_nettype none
// Sensor front end that faces the alarm block from the far side.
module pam_sense_model
  import pam_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // Requested conditions.
  input  wire pam_sense_t want_in,
  input  wire logic       replace_in,
  // Detector outputs.
  output var  pam_sense_t sense_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rep_q;
  // Levels follow the request one cycle late, like a filtered comparator.
  // The battery switch reports only its closing edge, as a single pulse.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sense_out <= '0;
      sense_out.mains_ok <= 1'b1;
      rep_q <= 1'b0;
    end else begin
      sense_out <= want_in;
      sense_out.ext_replaced <= replace_in & ~rep_q;
      rep_q <= replace_in;
    end
  end
endmodule : pam_sense_model
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench
  import pam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int I_TM = 20, I_TH = 19, I_BK = 18, I_MSG = 17, I_CB = 16;
  localparam int I_IB = 15, I_LV = 13, I_PL = 11, I_LI = 10, I_CP = 9;
  localparam int I_SV = 8;
  logic        sys_clk_in, rst_b_in, psel, penable, pwrite, key, power_on_self_test, rep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_out, q;
  logic        pready_out, pslverr_out, e, power_on_self_test_run_out, resume_out;
  logic [3:0]  mode_out;
  logic [7:0]  alarms_out;
  pam_ind_t    ind_out;
  pam_sense_t  sset, sense;
  wire  [31:0] obs;
  int          n_mismatch, n_checks, cyc, seed, n, m_ctrl, m_mode;
  assign obs = {9'h0, resume_out, power_on_self_test_run_out, ind_out, alarms_out};
  // Short counts keep each two minute alarm to about thirty cycles.
  pam_top #(.CYC_PER_SEC(10), .ALARM_SEC(3), .HOLD_SEC(3)) u_dut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .sense_in(sense),
    .reset_key_in(key), .power_on_self_test_done_in(power_on_self_test), .ind_out(ind_out),
    .power_on_self_test_run_out(power_on_self_test_run_out), .mode_out(mode_out),
    .resume_out(resume_out), .alarms_out(alarms_out));
  pam_sense_model u_sense (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .want_in(sset), .replace_in(rep), .sense_out(sense));
  // Clock and run limit; a hang is reported as a mismatch.
  always #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // One APB transfer; the answer is taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_in);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(posedge sys_clk_in);
    while (pready_out !== 1'b1) @(posedge sys_clk_in);
    q = prdata_out;
    e = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits a bounded time for one observed bit, then compares it.
  task automatic wt(input int i, input logic v);
    n = 0;
    @(negedge sys_clk_in);
    while (obs[i] !== v && n < 60) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk(obs[i], v);
  endtask : wt
  // A flashing bit must take both values within twelve cycles.
  task automatic fl(input int i);
    int ones;
    ones = 0;
    repeat (12) begin
      @(negedge sys_clk_in);
      ones += int'(obs[i] === 1'b1);
    end
    chk(ones > 0 && ones < 12, 1);
  endtask : fl
  task automatic pulse(input int w);
    @(posedge sys_clk_in);
    case (w)
      0: power_on_self_test <= 1'b1;
      1: key <= 1'b1;
      default: rep <= 1'b1;
    endcase
    @(posedge sys_clk_in);
    power_on_self_test <= 1'b0;
    key <= 1'b0;
    rep <= 1'b0;
  endtask : pulse
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Main sequence; the register model lives in m_ctrl and m_mode.
  initial begin
    {sys_clk_in, psel, penable, pwrite, key, power_on_self_test, rep} = '0;
    {paddr, pwdata, cyc, n_mismatch, n_checks} = '0;
    seed = 82;
    sset = '0;
    sset.mains_ok = 1'b1;
    sset.int_low = 1'b1;
    sset.ext_low = 1'b1;
    sset.batt_left_min = 8'h3c;
    sset.o2_pressure_ok = 1'b1;
    m_ctrl = 32'h15;
    m_mode = $random(seed) & 15;
    rst_b_in = 1'b0;
    repeat (16) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(q, m_ctrl);
    apb(1'b1, OFS_MODE, m_mode);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(q, m_mode);
    apb(1'b0, 12'h00c, 32'h0);
    chk({q[30:0], e}, 32'h1);
    $display("registers done");
    wt(3, 1'b1);
    wt(2, 1'b1);
    pulse(2);
    wt(2, 1'b0);
    wt(3, 1'b0);
    chk(power_on_self_test_run_out, 1'b1);
    pulse(0);
    wt(21, 1'b0);
    $display("boot checks done");
    sset.mains_ok <= 1'b0;
    sset.int_supplying <= 1'b1;
    wt(0, 1'b1);
    wt(I_TM, 1'b1);
    wt(I_TM, 1'b0);
    chk(n >= 15 && n <= 36, 1);
    chk(obs[I_MSG] & obs[I_CB] & alarms_out[0], 1'b1);
    fl(I_IB);
    sset.mains_ok <= 1'b1;
    wt(0, 1'b0);
    $display("mains loss done");
    sset.mains_ok <= 1'b0;
    sset.int_supplying <= 1'b0;
    sset.ext_supplying <= 1'b1;
    repeat (3) @(negedge sys_clk_in);
    fl(14);
    chk(obs[I_IB], 1'b0);
    sset.ext_supplying <= 1'b0;
    sset.int_supplying <= 1'b1;
    wt(7, 1'b1);
    sset.mains_ok <= 1'b1;
    wt(7, 1'b0);
    wt(0, 1'b0);
    sset.ext_supplying <= 1'b1;
    repeat (3) @(negedge sys_clk_in);
    sset.ext_supplying <= 1'b0;
    wt(7, 1'b1);
    wt(I_TM, 1'b1);
    pulse(2);
    wt(7, 1'b0);
    wt(I_TM, 1'b0);
    $display("battery switch done");
    sset.o2_pressure_ok <= 1'b0;
    repeat (6) @(negedge sys_clk_in);
    chk(alarms_out[4], 1'b0);
    m_ctrl = 22 + ($random(seed) & 63);
    apb(1'b1, OFS_CTRL, m_ctrl);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(q, m_ctrl);
    wt(4, 1'b1);
    sset.o2_pressure_ok <= 1'b1;
    wt(4, 1'b0);
    sset.o2_sensor_bad <= 1'b1;
    wt(5, 1'b1);
    sset.o2_sensor_bad <= 1'b0;
    repeat (40) @(negedge sys_clk_in);
    chk(alarms_out[5], 1'b1);
    pulse(1);
    wt(5, 1'b0);
    apb(1'b1, OFS_CTRL, m_ctrl | 32'h100);
    sset.o2_sensor_bad <= 1'b1;
    repeat (6) @(negedge sys_clk_in);
    chk(alarms_out[5], 1'b0);
    sset.o2_sensor_bad <= 1'b0;
    pulse(1);
    apb(1'b1, OFS_CTRL, m_ctrl);
    $display("oxygen done");
    sset.speaker_fail <= 1'b1;
    wt(6, 1'b1);
    wt(I_BK, 1'b1);
    pulse(1);
    repeat (40) @(negedge sys_clk_in);
    chk(alarms_out[6], 1'b1);
    sset.speaker_fail <= 1'b0;
    pulse(1);
    wt(6, 1'b0);
    $display("speaker done");
    sset.mains_ok <= 1'b0;
    sset.batt_left_min <= 8'h06;
    repeat (6) @(negedge sys_clk_in);
    chk(alarms_out[1], 1'b0);
    sset.batt_left_min <= TPL_LEFT_MIN;
    wt(1, 1'b1);
    wt(I_TH, 1'b1);
    chk(obs[I_LV], 1'b0);
    fl(I_PL);
    fl(12);
    sset.batt_depleted <= 1'b1;
    wt(21, 1'b1);
    wt(I_SV, 1'b1);
    pulse(0);
    wt(I_LI, 1'b1);
    chk(obs[I_CP] & obs[I_BK] & alarms_out[1], 1'b1);
    sset.mains_ok <= 1'b1;
    sset.batt_depleted <= 1'b0;
    wt(1, 1'b0);
    wt(21, 1'b1);
    pulse(0);
    wt(22, 1'b1);
    chk(mode_out, m_mode);
    chk(alarms_out[3], 1'b0);
    $display("power loss done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
